// ### logic/emp_mac_port.sv
`timescale 1ns/10ps
module emp_mac_port (
	// Clock and reset
	input  wire logic           clk,
	input  wire logic           arst_n,
	// AXI4-Lite write
	input  wire logic [7:0]     s_axi_awaddr,
	input  wire logic           s_axi_awvalid,
	output logic                s_axi_awready,
	input  wire logic [31:0]    s_axi_wdata,
	input  wire logic [3:0]     s_axi_wstrb,
	input  wire logic           s_axi_wvalid,
	output logic                s_axi_wready,
	output logic [1:0]          s_axi_bresp,
	output logic                s_axi_bvalid,
	input  wire logic           s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]     s_axi_araddr,
	input  wire logic           s_axi_arvalid,
	output logic                s_axi_arready,
	output logic [31:0]         s_axi_rdata,
	output logic [1:0]          s_axi_rresp,
	output logic                s_axi_rvalid,
	input  wire logic           s_axi_rready,
	// PHY receive and transmit
	input  wire logic           phyClk,
	input  wire logic           phyTxClk,
	input  wire emp_pkg::emp_rx_t rxIn,
	output emp_pkg::emp_tx_t    txOut,
	// Management
	output logic                mdc,
	input  wire logic           mdioIn,
	output logic                mdioOut,
	output logic                mdioOe,
	// Timer event pins
	input  wire logic [1:0]     timerPinIn,
	output logic [1:0]          timerPinOut,
	output logic [1:0]          timerPinOe,
	output logic                irq,
	output logic                dmaReq
);
	import emp_pkg::*;

	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] s);
		for (int i = 0; i < 4; i++)
			if (s[i])
				o[i*8 +: 8] = d[i*8 +: 8];
		return o;
	endfunction

	// Synchronisers for everything from pins
	logic [12:0] syncA, syncB;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			syncA <= 13'h0;
			syncB <= 13'h0;
		end else begin
			syncA <= {timerPinIn, mdioIn, phyTxClk, phyClk, rxIn};
			syncB <= syncA;
		end
	end
	emp_rx_t rx;
	logic    rxClkS, txClkS, mdioS;
	logic [1:0] tpS;
	assign {tpS, mdioS, txClkS, rxClkS, rx} = syncB;

	// ctrl: 0 rmii, 1 full duplex, 2 unused, 3 tx start, 4 tx error
	logic [31:0] ctrlReg, ctrlNext, txdReg, txdNext, mdioReg, mdioNext;
	logic [31:0] tcsrReg [CHANNELS], tcsrNext [CHANNELS];
	logic [31:0] timerReg, timerNext;
	logic        bvReg, bvNext, rvReg, rvNext;
	logic [1:0]  brReg, brNext, rrReg, rrNext;
	logic [31:0] rdReg, rdNext;
	logic        rxClkPrev, txClkPrev, rxEdge, txEdge;
	logic        rmii, fullDup;
	assign rmii    = ctrlReg[0]; // R02
	assign fullDup = ctrlReg[1]; // R01
	// In RMII both directions use the reference clock on phyClk
	assign rxEdge = rxClkS & ~rxClkPrev; // R07 R17
	assign txEdge = rmii ? rxEdge : (txClkS & ~txClkPrev); // R13 R17

	// Receive shift path
	logic [31:0] rxWordReg, rxWordNext;
	logic [5:0]  rxBitsReg, rxBitsNext;
	logic        rxErrReg, rxErrNext, crsReg, crsNext, colReg, colNext;
	logic        rxDoneReg, rxDoneNext, rxActReg, rxActNext;
	logic        rdRx;

	always_comb begin
		rxWordNext = rxWordReg;
		rxBitsNext = rxBitsReg;
		rxErrNext  = rxErrReg;
		rxActNext  = rxActReg;
		rxDoneNext = rxDoneReg & ~rdRx;
		crsNext    = rmii ? rx.rxDv : rx.crs; // R10
		colNext    = rx.col & ~fullDup; // R22
		if (rxEdge) begin
			rxActNext = rx.rxDv;
			if (rx.rxDv) begin // R11
				if (!rxActReg) begin
					rxBitsNext = 6'h0;
					rxErrNext  = 1'b0;
				end
				if (rmii) begin
					rxWordNext = {rx.rxD[1:0], rxWordReg[31:2]};
					rxBitsNext = rxBitsNext + 6'h2;
				end else begin
					rxWordNext = {rx.rxD, rxWordReg[31:4]};
					rxBitsNext = rxBitsNext + 6'h4;
				end
				if (rx.rxEr)
					rxErrNext = 1'b1; // R12
			end else if (rxActReg)
				rxDoneNext = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rxWordReg <= 32'h0;
			rxBitsReg <= 6'h0;
			rxErrReg  <= 1'b0;
			rxActReg  <= 1'b0;
			rxDoneReg <= 1'b0;
			crsReg    <= 1'b0;
			colReg    <= 1'b0;
			rxClkPrev <= 1'b0;
			txClkPrev <= 1'b0;
		end else begin
			rxWordReg <= rxWordNext;
			rxBitsReg <= rxBitsNext;
			rxErrReg  <= rxErrNext;
			rxActReg  <= rxActNext;
			rxDoneReg <= rxDoneNext;
			crsReg    <= crsNext;
			colReg    <= colNext;
			rxClkPrev <= rxClkS;
			txClkPrev <= txClkS;
		end
	end

	// Transmit: sends the 32-bit word then drops enable; a half-duplex collision drops enable early
	emp_tx_t    txReg, txNext;
	logic [5:0] txLeftReg, txLeftNext;
	logic [31:0] txShReg, txShNext;
	logic        txStart;
	always_comb begin
		txNext     = txReg;
		txLeftNext = txLeftReg;
		txShNext   = txShReg;
		if (txEdge) begin
			if (txLeftReg != 6'h0 && !(colReg && !fullDup)) begin
				txNext.txEn = 1'b1; // R15
				txNext.txEr = ctrlReg[4]; // R16
				if (rmii) begin
					txNext.txD = {2'b00, txShReg[1:0]};
					txShNext   = {2'b00, txShReg[31:2]};
					txLeftNext = txLeftReg - 6'h2;
				end else begin
					txNext.txD = txShReg[3:0];
					txShNext   = {4'h0, txShReg[31:4]};
					txLeftNext = txLeftReg - 6'h4;
				end
			end else begin
				txNext     = '0; // R14 R15
				txLeftNext = 6'h0;
			end
		end else if (txStart && txLeftReg == 6'h0 && !txReg.txEn) begin
			txShNext   = txdReg;
			txLeftNext = 6'd32;
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			txReg     <= '0;
			txLeftReg <= 6'h0;
			txShReg   <= 32'h0;
		end else begin
			txReg     <= txNext;
			txLeftReg <= txLeftNext;
			txShReg   <= txShNext;
		end
	end
	assign txOut = txReg; // R13

	// Management clock and single-bit shifter
	// mdio reg: 15:0 data, 20:16 bits left, 21 drive, 22 busy, 23 armed
	logic [7:0] mdcCntReg, mdcCntNext;
	logic       mdcReg, mdcNext, mdcFall, mdcRise;
	always_comb begin
		mdcCntNext = mdcCntReg + 8'h1;
		mdcNext    = mdcReg;
		mdcFall    = 1'b0;
		mdcRise    = 1'b0;
		if (mdcCntReg == 8'(MDC_DIV - 1)) begin
			mdcCntNext = 8'h0;
			mdcNext    = ~mdcReg; // R05
			mdcFall    = mdcReg;
			mdcRise    = ~mdcReg;
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mdcCntReg <= 8'h0;
			mdcReg    <= 1'b0;
		end else begin
			mdcCntReg <= mdcCntNext;
			mdcReg    <= mdcNext;
		end
	end
	assign mdc     = mdcReg;
	assign mdioOut = mdioReg[15];
	assign mdioOe  = mdioReg[22] & mdioReg[21]; // R06

	// Timer and channels
	logic [31:0] chVal [CHANNELS];
	logic [CHANNELS-1:0] chFlag, chIrq, chDma, chWe, chClr;
	for (genvar g = 0; g < CHANNELS; g++) begin : gChan
		emp_timer_chan uChan (
			.clk      (clk),
			.arst_n   (arst_n),
			.ctrl     (tcsrReg[g][3:0]),
			.timerVal (timerReg),
			.cmpWr    (s_axi_wdata),
			.cmpWe    (chWe[g]),
			.flagClr  (chClr[g]),
			.pinSync  (tpS[g]),
			.pinOut   (timerPinOut[g]),
			.pinOe    (timerPinOe[g]),
			.value    (chVal[g]),
			.flag     (chFlag[g]),
			.irq      (chIrq[g]),
			.dmaReq   (chDma[g])
		);
	end
	assign irq    = |chIrq; // R20
	assign dmaReq = |chDma; // R20

	// Register slave: takes a write when address and data both present
	logic wrGo, rdGo;
	assign wrGo = s_axi_awvalid & s_axi_wvalid & ~bvReg;
	assign rdGo = s_axi_arvalid & ~rvReg;
	assign s_axi_awready = wrGo;
	assign s_axi_wready  = wrGo;
	assign s_axi_arready = rdGo;
	assign rdRx = rdGo && s_axi_araddr == ADDR_RXD;
	assign txStart = ctrlReg[3];

	always_comb begin
		ctrlNext  = ctrlReg;
		txdNext   = txdReg;
		mdioNext  = mdioReg;
		timerNext = timerReg + 32'h1;
		tcsrNext  = tcsrReg;
		chWe      = '0;
		chClr     = '0;
		bvNext    = bvReg & ~s_axi_bready;
		brNext    = brReg;
		rvNext    = rvReg & ~s_axi_rready;
		rrNext    = rrReg;
		rdNext    = rdReg;
		if (txStart && txLeftReg == 6'h0 && !txReg.txEn && !txEdge)
			ctrlNext[3] = 1'b0;
		// Armed by a rising mdc so bit 15 is seen before the first shift
		if (mdioReg[22] && mdcRise)
			mdioNext[23] = 1'b1; // R05
		if (mdioReg[23:22] == 2'b11 && mdcFall) begin
			mdioNext[15:0] = {mdioReg[14:0], mdioS};
			mdioNext[20:16] = mdioReg[20:16] - 5'h1;
			if (mdioReg[20:16] == 5'h0)
				mdioNext[23:22] = 2'b00;
		end
		if (wrGo) begin
			bvNext = 1'b1;
			brNext = RESP_OKAY;
			if (s_axi_awaddr == ADDR_CTRL)
				ctrlNext = merge(ctrlReg, s_axi_wdata, s_axi_wstrb);
			else if (s_axi_awaddr == ADDR_TXD)
				txdNext = merge(txdReg, s_axi_wdata, s_axi_wstrb);
			else if (s_axi_awaddr == ADDR_MDIO) begin
				mdioNext = {9'h0, 1'b1, s_axi_wdata[21:0]};
			end else if (s_axi_awaddr == ADDR_TIMER)
				timerNext = s_axi_wdata;
			else if (s_axi_awaddr == ADDR_TCSR0 ||
				s_axi_awaddr == ADDR_TCSR1) begin
				tcsrNext[s_axi_awaddr[3]] = {28'h0, s_axi_wdata[3:0]};
				chClr[s_axi_awaddr[3]] = s_axi_wdata[7]; // write 1 clears
			end else if (s_axi_awaddr == ADDR_TCCR0 ||
				s_axi_awaddr == ADDR_TCCR1)
				chWe[s_axi_awaddr[3]] = 1'b1;
			else
				brNext = RESP_SLVERR;
		end
		if (rdGo) begin
			rvNext = 1'b1;
			rrNext = RESP_OKAY;
			if (s_axi_araddr == ADDR_CTRL)
				rdNext = ctrlReg;
			else if (s_axi_araddr == ADDR_STATUS)
				rdNext = {21'h0, mdioReg[22], rxBitsReg, rxErrReg,
					rxDoneReg, crsReg, colReg};
			else if (s_axi_araddr == ADDR_TXD)
				rdNext = txdReg;
			else if (s_axi_araddr == ADDR_RXD)
				rdNext = rxWordReg;
			else if (s_axi_araddr == ADDR_MDIO)
				rdNext = mdioReg;
			else if (s_axi_araddr == ADDR_TIMER)
				rdNext = timerReg;
			else if (s_axi_araddr == ADDR_TCSR0 ||
				s_axi_araddr == ADDR_TCSR1)
				rdNext = {24'h0, chFlag[s_axi_araddr[3]], 3'h0,
					tcsrReg[s_axi_araddr[3]][3:0]};
			else if (s_axi_araddr == ADDR_TCCR0 ||
				s_axi_araddr == ADDR_TCCR1)
				rdNext = chVal[s_axi_araddr[3]];
			else begin
				rdNext = 32'h0;
				rrNext = RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrlReg  <= 32'h0;
			txdReg   <= 32'h0;
			mdioReg  <= 32'h0;
			timerReg <= 32'h0;
			tcsrReg  <= '{default: 32'h0};
			bvReg    <= 1'b0;
			brReg    <= RESP_OKAY;
			rvReg    <= 1'b0;
			rrReg    <= RESP_OKAY;
			rdReg    <= 32'h0;
		end else begin
			ctrlReg  <= ctrlNext;
			txdReg   <= txdNext;
			mdioReg  <= mdioNext;
			timerReg <= timerNext;
			tcsrReg  <= tcsrNext;
			bvReg    <= bvNext;
			brReg    <= brNext;
			rvReg    <= rvNext;
			rrReg    <= rrNext;
			rdReg    <= rdNext;
		end
	end
	assign s_axi_bvalid = bvReg;
	assign s_axi_bresp  = brReg;
	assign s_axi_rvalid = rvReg;
	assign s_axi_rresp  = rrReg;
	assign s_axi_rdata  = rdReg;
endmodule // emp_mac_port

// ### logic/emp_timer_chan.sv
`timescale 1ns/10ps
module emp_timer_chan (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Control
	input  wire logic [3:0]  ctrl,
	input  wire logic [31:0] timerVal,
	input  wire logic [31:0] cmpWr,
	input  wire logic        cmpWe,
	input  wire logic        flagClr,
	// Pin
	input  wire logic        pinSync,
	output logic             pinOut,
	output logic             pinOe,
	// Results
	output logic [31:0]      value,
	output logic             flag,
	output logic             irq,
	output logic             dmaReq
);
	import emp_pkg::*;
	// ctrl: 0 enable, 1 compare mode, 2 irq enable, 3 dma enable
	logic [31:0] valueReg, valueNext;
	logic        flagReg, flagNext, prevReg, pulseReg, pulseNext, evt;

	always_comb begin
		evt = 1'b0;
		valueNext = valueReg;
		pulseNext = 1'b0;
		if (ctrl[0] && !ctrl[1] && pinSync && !prevReg) begin
			evt = 1'b1;
			valueNext = timerVal; // R18
		end
		if (ctrl[0] && ctrl[1] && timerVal == valueReg) begin
			evt = 1'b1;
			pulseNext = 1'b1; // R19
		end
		if (cmpWe)
			valueNext = cmpWr;
		flagNext = evt | (flagReg & ~flagClr);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			valueReg <= 32'h0;
			flagReg  <= 1'b0;
			prevReg  <= 1'b0;
			pulseReg <= 1'b0;
		end else begin
			valueReg <= valueNext;
			flagReg  <= flagNext;
			prevReg  <= pinSync;
			pulseReg <= pulseNext;
		end
	end

	assign value  = valueReg;
	assign flag   = flagReg;
	assign pinOut = pulseReg;
	assign pinOe  = ctrl[0] & ctrl[1];
	assign irq    = flagReg & ctrl[2]; // R20
	assign dmaReq = flagReg & ctrl[3]; // R20
endmodule // emp_timer_chan

// ### shared/emp_pkg.sv
// Operation
// R01: 10 or 100 Mbit/s, half or full duplex
// R02: MII, reduced MII or RMII port
// R03: PHY holds collision while it lasts
// R04: PHY raises carrier sense when medium busy
// R05: MAC drives management clock for data
// R06: Management data pin input after reset
// R07: MII receive signals sampled on receive clock
// R08: PHY holds valid across whole frame
// R09: Valid starts by delimiter, excludes end
// R10: RMII carrier and valid from one input
// R11: Take data only while valid, 4/2 bits
// R12: Receive error with valid marks frame errored
// R13: MII transmit launched on transmit clock
// R14: Transmit data meaningful only while enabled
// R15: Enable with preamble, drop after last nibble
// R16: Transmit error while enabled makes bad symbols
// R17: RMII reference clock times everything
// R18: Capture latches timer on rising pin edge
// R19: Compare pulses pin one cycle on match
// R20: Timer event raises interrupt or DMA request
// R21: Alternate timestamp clock whole nanoseconds; the timer counts only clk, with no alternate clock
// R22: Full duplex ignores collision input
package emp_pkg;
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_TXD    = 8'h08;
	localparam logic [7:0] ADDR_RXD    = 8'h0c;
	localparam logic [7:0] ADDR_MDIO   = 8'h10;
	localparam logic [7:0] ADDR_TIMER  = 8'h14;
	localparam logic [7:0] ADDR_TCSR0  = 8'h20;
	localparam logic [7:0] ADDR_TCCR0  = 8'h24;
	localparam logic [7:0] ADDR_TCSR1  = 8'h28;
	localparam logic [7:0] ADDR_TCCR1  = 8'h2c;
	localparam int         MDC_DIV     = 50;
	localparam int         CHANNELS    = 2;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {
		EMP_MII  = 2'b00,
		EMP_RMII = 2'b01
	} emp_mode_t;
	typedef struct packed {
		logic       rxDv;
		logic       rxEr;
		logic [3:0] rxD;
		logic       crs;
		logic       col;
	} emp_rx_t;
	typedef struct packed {
		logic       txEn;
		logic       txEr;
		logic [3:0] txD;
	} emp_tx_t;
endpackage

// ### tb/emp_mac_port_sva.sv
`timescale 1ns/10ps
module emp_mac_port_sva import emp_pkg::*; (
	// Clock and reset
	input wire logic             clk,
	input wire logic             arst_n,
	// Register bus
	input wire logic             s_axi_awvalid,
	input wire logic             s_axi_wvalid,
	input wire logic             s_axi_bvalid,
	input wire logic             s_axi_arvalid,
	input wire logic [7:0]       s_axi_araddr,
	input wire logic             s_axi_rvalid,
	input wire logic             s_axi_rready,
	input wire logic [31:0]      s_axi_rdata,
	input wire logic [1:0]       s_axi_rresp,
	// Pins
	input wire emp_pkg::emp_tx_t txOut,
	input wire logic             mdc,
	input wire logic             mdioOe,
	input wire logic [1:0]       timerPinOut,
	input wire logic [1:0]       timerPinOe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid
		&& !s_axi_bvalid |=> s_axi_bvalid) else $error("no write answer");
	rd_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid
		|=> s_axi_rvalid) else $error("no read answer");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
	unmapped_a: assert property (s_axi_arvalid && !s_axi_rvalid
		&& s_axi_araddr == 8'h3c |=> s_axi_rresp == RESP_SLVERR)
		else $error("unmapped read not refused");
	tx_frame_a: assert property ($rose(txOut.txEn)
		|=> txOut.txEn [*8]) else $error("tx enable short");
	mdc_high_a: assert property ($rose(mdc) |=> mdc [*8])
		else $error("mdc high too short");
	mdc_low_a: assert property ($fell(mdc) |=> !mdc [*8])
		else $error("mdc low too short");
	pulse_one_a: assert property (
		!(|(timerPinOut & $past(timerPinOut))))
		else $error("compare pulse too long");
	pin_drive_a: assert property (!(|(timerPinOut & ~timerPinOe)))
		else $error("pin pulse undriven");
	cover property ($rose(txOut.txEn));
	cover property ($rose(timerPinOut[0]));
	cover property ($rose(mdioOe));
endmodule // emp_mac_port_sva

// ### tb/emp_mac_port_tb.sv
`timescale 1ns/10ps
module emp_mac_port_tb;
	import emp_pkg::*;
	logic        clk, arst_n, phyClk, phyTxClk, mdc, mdioIn, mdioOut, mdioOe;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, irq, dmaReq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [1:0]  timerPinIn, timerPinOut, timerPinOe;
	emp_rx_t     rxIn;
	emp_tx_t     txOut;
	int          n_mismatch = 0;
	int          tests_run = 0;
	int          n;
	emp_mac_port u_dut (.*);
	emp_phy_model u_phy (.*);
	// Timer counts this clock, so its period is whole nanoseconds
	always #2.5 clk = ~clk;
	task give_verdict;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, g);
		tests_run++;
		if (e !== g) begin
			$display("[ERR] %s exp %h got %h", s, e, g);
			n_mismatch++;
		end
	endtask
	// Every wait is bounded; running out ends the run
	task lim;
		if (n >= 3000) begin
			chk("wait limit", 0, 1);
			give_verdict;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		for (n = 0; n < 3000; n++) begin
			@(negedge clk);
			if (s_axi_awready && s_axi_wready) break;
		end
		lim;
		@(posedge clk);
		s_axi_awvalid <= 0;
		s_axi_wvalid <= 0;
		s_axi_bready <= 1;
		for (n = 0; n < 3000 && !s_axi_bvalid; n++) @(negedge clk);
		lim;
		rs = s_axi_bresp;
		@(posedge clk);
		s_axi_bready <= 0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] m, e, input string s);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		for (n = 0; n < 3000 && !s_axi_arready; n++) @(negedge clk);
		lim;
		@(posedge clk);
		s_axi_arvalid <= 0;
		s_axi_rready <= 1;
		for (n = 0; n < 3000 && !s_axi_rvalid; n++) @(negedge clk);
		lim;
		rv = s_axi_rdata;
		rs = s_axi_rresp;
		@(posedge clk);
		s_axi_rready <= 0;
		chk(s, e, rv & m);
	endtask
	initial begin
		clk = 0;
		arst_n = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, timerPinIn} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		repeat (2) @(posedge clk);
		arst_n <= 1;
		@(posedge clk);
		chk("mdioOe", 0, mdioOe);
		chk("txEn", 0, txOut.txEn);
		rd(8'h3c, '1, 0, "unmapped");
		chk("rresp", RESP_SLVERR, rs);
		wr(8'h3c, 32'h0);
		chk("bresp err", RESP_SLVERR, rs);
		$display("test reset done");
		wr(ADDR_CTRL, 32'h2);
		chk("bresp ok", RESP_OKAY, rs);
		u_phy.send(32'ha5c3_1e72, 0);
		rd(ADDR_STATUS, 32'hc, 32'h4, "rx done");
		rd(ADDR_RXD, '1, 32'ha5c3_1e72, "rx word");
		u_phy.send(32'h0f0f_3c3c, 1);
		rd(ADDR_STATUS, 32'h8, 32'h8, "rx error");
		wr(ADDR_CTRL, 32'h3);
		u_phy.rmii = 1;
		u_phy.send(32'h9e37_79b9, 0);
		rd(ADDR_RXD, '1, 32'h9e37_79b9, "rmii word");
		u_phy.rmii = 0;
		$display("test receive done");
		wr(ADDR_CTRL, 32'h2);
		u_phy.rxIn.col = 1;
		wr(ADDR_TXD, 32'h1234_abcd);
		wr(ADDR_CTRL, 32'ha);
		for (n = 0; n < 3000 && u_phy.txCnt < 8; n++) @(negedge clk);
		lim;
		chk("tx word", 32'h1234_abcd, u_phy.txWord);
		for (n = 0; n < 3000 && txOut.txEn; n++) @(negedge clk);
		lim;
		u_phy.rxIn.col = 0;
		wr(ADDR_CTRL, 32'h1a);
		for (n = 0; n < 3000 && u_phy.txCnt < 16; n++) @(negedge clk);
		lim;
		chk("tx error", 1, u_phy.sawEr);
		$display("test transmit done");
		wr(ADDR_TCSR0, 32'h7);
		wr(ADDR_TCCR0, 32'h100);
		wr(ADDR_TIMER, 0);
		for (n = 0; n < 3000 && !timerPinOut[0]; n++) @(negedge clk);
		lim;
		chk("pin oe", 2'b01, timerPinOe);
		rd(ADDR_TCSR0, 32'h80, 32'h80, "flag");
		chk("irq", 1, irq);
		wr(ADDR_TCSR0, 32'h87);
		chk("irq clear", 0, irq);
		wr(ADDR_TCSR1, 32'h9);
		wr(ADDR_TIMER, 0);
		timerPinIn <= 2'b10;
		for (n = 0; n < 3000 && !dmaReq; n++) @(negedge clk);
		lim;
		chk("irq gated", 0, irq);
		rd(ADDR_TCCR1, 32'hffff_ffc0, 0, "capture");
		chk("capture nz", 1, rv != 0);
		$display("test timer done");
		wr(ADDR_MDIO, 32'h002f_a5f0);
		for (n = 0; n < 3000 && !mdioOe; n++) @(negedge clk);
		lim;
		for (n = 0; n < 3000 && mdioOe; n++) @(negedge clk);
		lim;
		chk("mdio word", 32'ha5f0, u_phy.mdWord);
		rd(ADDR_STATUS, 32'h400, 0, "mdio idle");
		$display("test management done");
		give_verdict;
	end
endmodule // emp_mac_port_tb
bind emp_mac_port emp_mac_port_sva u_sva (.*);

// ### tb/emp_phy_model.sv
`timescale 1ns/10ps
module emp_phy_model import emp_pkg::*; (
	// Clocks
	output logic                 phyClk,
	output logic                 phyTxClk,
	// Data
	output emp_pkg::emp_rx_t     rxIn,
	input wire emp_pkg::emp_tx_t txOut,
	// Management
	input wire logic             mdc,
	input wire logic             mdioOut,
	input wire logic             mdioOe,
	output logic                 mdioIn
);
	logic        rmii = 0;
	logic        sawEr = 0;
	logic [31:0] txWord = '0;
	logic [15:0] mdWord = '0;
	int          txCnt = 0;
	// Odd phases so no edge meets the core clock edge
	initial begin
		phyClk = 0;
		phyTxClk = 0;
		rxIn = '0;
		#3.3;
		forever #40 phyClk = ~phyClk;
	end
	initial begin
		#17.1;
		forever #40 phyTxClk = ~phyTxClk;
	end
	assign mdioIn = mdioOe ? mdioOut : 1'b1; // Pull-up when released
	always @(posedge phyTxClk) if (txOut.txEn) begin
		txWord <= {txOut.txD, txWord[31:4]};
		txCnt <= txCnt + 1;
		if (txOut.txEr) sawEr <= 1;
	end
	always @(posedge mdc) if (mdioOe) mdWord <= {mdWord[14:0], mdioOut};
	task automatic send(input logic [31:0] w, input logic er);
		int i;
		for (i = 0; i < (rmii ? 16 : 8); i++) begin
			@(negedge phyClk);
			rxIn.rxDv = 1;
			rxIn.crs = !rmii;
			rxIn.rxEr = er && i == 3;
			rxIn.rxD = rmii ? {2'b00, w[2*i+:2]} : w[4*i+:4];
		end
		@(negedge phyClk);
		rxIn.rxDv = 0;
		rxIn.crs = 0;
		rxIn.rxD = ~rxIn.rxD;
		@(negedge phyClk);
	endtask
endmodule // emp_phy_model
